/* File: hdl/cscv_clock_source_config.sv */
/*
 clock source configuration and vco calibration control.
 holds buffered and active register banks, commits on the update strobe,
 decodes power mode and source path, sequences calibration, and saves or
 restores the active configuration through the nonvolatile store.
 assumes a synchronous register port on clk_sys, one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module cscv_clock_source_config
    import cscv_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    output logic      [DATA_W-1:0] regRdata,
    output logic                   regRvalid,
    output logic                   pllPowerOn,
    output logic                   pllPowerDown,
    output logic      [1:0]        pllPowerMode,
    output logic                   pfdNegative,
    output logic                   srcInternalVco,
    output logic                   vcoDivBypass,
    output logic      [2:0]        vcoDivRatio,
    output logic      [2:0]        refInputEn,
    output logic                   calBusy,
    output logic                   calDone
);
    // the cap keeps every run length inside the 13-bit run counter
    localparam int CAL_MAX = 4096;
    if (CAL_LEN < 1 || CAL_LEN > CAL_MAX) begin : g_cal_len_check
        $error("CAL_LEN out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // register banks
    cscv_cfg_t shadowQ;
    cscv_cfg_t shadowD;
    cscv_cfg_t activeQ;
    cscv_cfg_t activeD;
    cscv_cal_t calStateQ;
    cscv_cal_t calStateD;
    logic [12:0] calCntQ;
    logic [12:0] calCntD;

    // read port and restore handshake
    logic [DATA_W-1:0] rdataQ;
    logic              rvalidQ;
    logic              loadPendQ;
    cscv_cfg_t         nvmData;
    logic              nvmValid;

    // address compare, shared by write decode and readback
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction

    wire logic wrUpdate = regWr && hit(regAddr, OFS_UPDATE) && regWdata[BIT_UPDATE];
    wire logic wrNvm    = regWr && hit(regAddr, OFS_NVM_CTRL);
    wire logic nvmStore = wrNvm && regWdata[BIT_NVM_STORE];
    wire logic nvmLoad  = wrNvm && regWdata[BIT_NVM_LOAD];
    wire logic calBitNew = activeD.vcoCal[BIT_CAL];
    wire logic calBitOld = activeQ.vcoCal[BIT_CAL];
    // rising cal bit at commit starts a run; a held one does not re-arm
    wire logic calStart = wrUpdate && calBitNew && !calBitOld;

    //////////////////////////////////////////////////////////////////////////
    // buffered writes; shadow follows register port
    // restore also reloads the shadow so a later strobe cannot bring back stale values
    always_comb begin
        shadowD = shadowQ;
        if (regWr) begin
            if (hit(regAddr, OFS_PLL_PWR)) shadowD.pllPwr = regWdata;
            if (hit(regAddr, OFS_VCO_CAL)) shadowD.vcoCal = regWdata;
            if (hit(regAddr, OFS_REF_EN))  shadowD.refEn  = regWdata;
            if (hit(regAddr, OFS_VCO_DIV)) shadowD.vcoDiv = regWdata;
            if (hit(regAddr, OFS_SRC_SEL)) shadowD.srcSel = regWdata;
        end
        if (loadPendQ) shadowD = nvmData;
    end

    // a restore outranks a strobe that lands in the same cycle
    // active bank changes only on update strobe or restore
    always_comb begin
        activeD = activeQ;
        if (wrUpdate) activeD = shadowQ;
        if (loadPendQ) activeD = nvmData;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shadowQ <= CFG_RESET;
            activeQ <= CFG_RESET;
        end else begin
            shadowQ <= shadowD;
            activeQ <= activeD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loadPendQ <= 1'b0;
        end else begin
            loadPendQ <= nvmLoad && nvmValid;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // calibration sequencer
    // a clearing commit during a run is ignored; the run always completes
    always_comb begin
        calStateD = calStateQ;
        calCntD   = calCntQ;
        unique case (calStateQ)
            CAL_IDLE, CAL_DONE: begin
                if (calStart) begin
                    calStateD = CAL_RUN;
                    calCntD   = 13'(CAL_LEN - 1);
                end else if (wrUpdate && !calBitNew) begin
                    calStateD = CAL_IDLE;
                end
            end
            CAL_RUN: begin
                // counts down from CAL_LEN-1, so busy stands CAL_LEN cycles
                if (calCntQ == 13'h0000) begin
                    calStateD = CAL_DONE;
                end else begin
                    calCntD = calCntQ - 13'h0001;
                end
            end
            default: calStateD = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            calStateQ <= CAL_IDLE;
            calCntQ   <= 13'h0000;
        end else begin
            calStateQ <= calStateD;
            calCntQ   <= calCntD;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // nonvolatile store
    // the active bank is saved; reset clears the valid flag, so it cannot be restored after power-up
    cscv_nvm u_nvm (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .store     (nvmStore),
        .storeData (activeQ),
        .loadData  (nvmData),
        .valid     (nvmValid)
    );

    //////////////////////////////////////////////////////////////////////////
    // readback of buffered values; status at the store control offset
    // the update strobe is not stored, so its offset reads as zero
    wire logic [DATA_W-1:0] rdMux =
        hit(regAddr, OFS_PLL_PWR)  ? shadowQ.pllPwr :
        hit(regAddr, OFS_VCO_CAL)  ? shadowQ.vcoCal :
        hit(regAddr, OFS_REF_EN)   ? shadowQ.refEn  :
        hit(regAddr, OFS_VCO_DIV)  ? shadowQ.vcoDiv :
        hit(regAddr, OFS_SRC_SEL)  ? shadowQ.srcSel :
        hit(regAddr, OFS_NVM_CTRL) ? {5'h00, calStateQ == CAL_DONE,
                                      calStateQ == CAL_RUN, nvmValid} :
        8'h00;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdataQ  <= 8'h00;
            rvalidQ <= 1'b0;
        end else begin
            rdataQ  <= regRd ? rdMux : 8'h00;
            rvalidQ <= regRd;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // decoded controls from the active bank
    assign pllPowerMode   = activeQ.pllPwr[1:0];
    assign pllPowerOn     = activeQ.pllPwr[1:0] == PWR_NORMAL;
    // the analog block takes this without a clock edge
    assign pllPowerDown   = activeQ.pllPwr[1:0] == PWR_ASYNC_OFF;
    assign pfdNegative    = activeQ.pllPwr[BIT_POLARITY];
    assign srcInternalVco = activeQ.srcSel[BIT_VCO_SEL];
    assign vcoDivBypass   = activeQ.srcSel[BIT_BYPASS];
    assign vcoDivRatio    = activeQ.vcoDiv[2:0];
    assign refInputEn     = activeQ.refEn[2:0];

    assign calBusy        = calStateQ == CAL_RUN;
    assign calDone        = calStateQ == CAL_DONE;

    assign regRdata       = rdataQ;
    assign regRvalid      = rvalidQ;
endmodule
`default_nettype wire

/* File: hdl/cscv_nvm.sv */
/*
 nonvolatile store model: holds one saved configuration word.
 assumes store and load are one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module cscv_nvm
    import cscv_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      reset,
    input  wire logic      store,
    input  wire cscv_cfg_t storeData,
    output cscv_cfg_t      loadData,
    output logic           valid
);
    // contents survive reset; only the valid flag and output follow it
    cscv_cfg_t memQ [NVM_WORDS / NVM_WORDS];
    logic      validQ;

    always_ff @(posedge clk_sys) begin
        if (store) begin
            memQ[0] <= storeData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            validQ <= 1'b0;
        end else if (store) begin
            validQ <= 1'b1;
        end
    end

    assign loadData = validQ ? memQ[0] : CFG_RESET;
    assign valid    = validQ;
endmodule
`default_nettype wire

/* File: hdl/cscv_pkg.sv */
/*
 clock source configuration package: register offsets, field positions,
 reset values, power modes and calibration states.
 assumes a register port with a 10-bit address and 8-bit data.
*/
`default_nettype none
package cscv_pkg;
    localparam int           ADDR_W        = 10;
    localparam int           DATA_W        = 8;
    localparam logic [9:0]   OFS_PLL_PWR   = 10'h010;
    localparam logic [9:0]   OFS_VCO_CAL   = 10'h018;
    localparam logic [9:0]   OFS_REF_EN    = 10'h01C;
    localparam logic [9:0]   OFS_VCO_DIV   = 10'h1E0;
    localparam logic [9:0]   OFS_SRC_SEL   = 10'h1E1;
    localparam logic [9:0]   OFS_UPDATE    = 10'h232;
    localparam logic [9:0]   OFS_NVM_CTRL  = 10'h0B2;
    localparam logic [7:0]   RST_PLL_PWR   = 8'h01;
    localparam logic [7:0]   RST_VCO_CAL   = 8'h00;
    localparam logic [7:0]   RST_REF_EN    = 8'h00;
    localparam logic [7:0]   RST_VCO_DIV   = 8'h00;
    localparam logic [7:0]   RST_SRC_SEL   = 8'h00;
    localparam int           BIT_CAL       = 0;
    localparam int           BIT_UPDATE    = 0;
    localparam int           BIT_BYPASS    = 0;
    localparam int           BIT_VCO_SEL   = 1;
    localparam int           BIT_NVM_STORE = 0;
    localparam int           BIT_NVM_LOAD  = 1;
    localparam int           BIT_POLARITY  = 7;
    localparam logic [1:0]   PWR_NORMAL    = 2'h0;
    localparam logic [1:0]   PWR_ASYNC_OFF = 2'h1;
    localparam int           CAL_CYCLES    = 64;
    localparam int           NVM_WORDS     = 5;

    typedef struct packed {
        logic [7:0] pllPwr;
        logic [7:0] vcoCal;
        logic [7:0] refEn;
        logic [7:0] vcoDiv;
        logic [7:0] srcSel;
    } cscv_cfg_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_DONE = 2'b10
    } cscv_cal_t;

    localparam cscv_cfg_t CFG_RESET = '{RST_PLL_PWR, RST_VCO_CAL, RST_REF_EN,
                                        RST_VCO_DIV, RST_SRC_SEL};
endpackage
`default_nettype wire

/* File: tb/cscv_cfg_properties.sv */
/*
 port-level checker for the clock source configuration block.
 assumes a bind onto cscv_clock_source_config, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cscv_cfg_properties
    import cscv_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)
(
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              regRvalid,
    input wire logic              pllPowerOn,
    input wire logic              pllPowerDown,
    input wire logic [1:0]        pllPowerMode,
    input wire logic              srcInternalVco,
    input wire logic              vcoDivBypass,
    input wire logic [2:0]        vcoDivRatio,
    input wire logic              calBusy,
    input wire logic              calDone
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // counts busy cycles; 16 bits is ample for any short test length
    logic [15:0] busyCnt_q;
    always_ff @(posedge clk_sys) begin
        if (reset)
            busyCnt_q <= 16'h0000;
        else
            busyCnt_q <= calBusy ? busyCnt_q + 16'h0001 : 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    a_pwr_on_decode: assert property (pllPowerOn == (pllPowerMode == PWR_NORMAL))
        else $error("power on decode wrong");
    a_pwr_down_decode: assert property (pllPowerDown == (pllPowerMode == PWR_ASYNC_OFF))
        else $error("power down decode wrong");
    // a strobe shows one cycle after the write and a restore two; the check looks three cycles back
    a_update_only: assert property (!$past(regWr) && !$past(regWr, 2) && !$past(regWr, 3)
        |-> $stable({srcInternalVco, vcoDivBypass, vcoDivRatio, pllPowerMode}))
        else $error("active outputs moved without a write");
    a_cal_length: assert property ($fell(calBusy) |-> calDone && busyCnt_q == CAL_LEN)
        else $error("calibration length wrong");
    a_busy_done_excl: assert property (!(calBusy && calDone))
        else $error("busy and done together");
    a_done_after_busy: assert property ($rose(calDone) |-> $past(calBusy))
        else $error("done without a calibration run");
    a_busy_cause: assert property ($rose(calBusy) |-> $past(regWr)
        && $past(regAddr) == OFS_UPDATE)
        else $error("calibration began without update");
    a_read_answer: assert property (regRd |=> regRvalid)
        else $error("read not answered");
    a_rdata_idle: assert property (!regRvalid |-> regRdata == 8'h00)
        else $error("read data not zero when idle");
    a_reset_defaults: assert property (disable iff (1'b0) reset |=> vcoDivRatio == 3'h0
        && pllPowerDown && !srcInternalVco && !vcoDivBypass)
        else $error("reset values wrong");
endmodule
bind cscv_clock_source_config cscv_cfg_properties #(.CAL_LEN(CAL_LEN)) chk (
    .clk_sys(clk_sys), .reset(reset), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regRdata(regRdata), .regRvalid(regRvalid), .pllPowerOn(pllPowerOn),
    .pllPowerDown(pllPowerDown), .pllPowerMode(pllPowerMode),
    .srcInternalVco(srcInternalVco), .vcoDivBypass(vcoDivBypass),
    .vcoDivRatio(vcoDivRatio), .calBusy(calBusy), .calDone(calDone));
`default_nettype wire

/* File: tb/cscv_clock_source_config_test.sv */
/*
 self-checking bench for the clock source configuration block.
 assumes the checker is bound in; short calibration length of 4.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module cscv_clock_source_config_test
    import cscv_pkg::*;
;
    localparam int CL = 4;
    logic       clk_sys = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWdata = 8'h00, regRdata, expV, rDiv, rRef;
    logic       regRvalid, pllPowerOn, pllPowerDown, pfdNegative;
    logic       srcInternalVco, vcoDivBypass, calBusy, calDone;
    logic [1:0] pllPowerMode;
    logic [2:0] vcoDivRatio, refInputEn;
    logic [7:0] expQ[$];
    logic [31:0] lfsr = 32'h81B9A1FD;
    int         err_total = 0, tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    cscv_clock_source_config #(.CAL_LEN(CL)) uut (
        .clk_sys(clk_sys), .reset(reset), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .pllPowerOn(pllPowerOn), .pllPowerDown(pllPowerDown),
        .pllPowerMode(pllPowerMode), .pfdNegative(pfdNegative),
        .srcInternalVco(srcInternalVco), .vcoDivBypass(vcoDivBypass),
        .vcoDivRatio(vcoDivRatio), .refInputEn(refInputEn),
        .calBusy(calBusy), .calDone(calDone));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1 regWr = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clk_sys) #1 regWr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clk_sys) #1 regRd = 1'b1;
        regAddr = a;
        @(posedge clk_sys) #1 regRd = 1'b0;
    endtask
    task automatic upd;
        wr(OFS_UPDATE, 8'h01);
        @(posedge clk_sys) #1;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // read answers are sampled mid-cycle, clear of the launching edge
    always @(negedge clk_sys) if (regRvalid === 1'b1) begin
        expV = expQ.pop_front();
        `CHK(regRdata, expV)
    end
    initial begin
        #(50 * 2000);
        err_total++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 reset = 1'b0;
        `CHK(vcoDivRatio, 3'h0)
        `CHK({pllPowerDown, pllPowerOn}, 2'b10)
        `CHK(pllPowerMode, PWR_ASYNC_OFF)
        rDiv = lfsr[7:0];
        lfsr = lfsrNext(lfsr);
        rRef = lfsr[7:0];
        wr(OFS_VCO_DIV, {5'h00, rDiv[2:0]});
        wr(OFS_REF_EN, {5'h00, rRef[2:0]});
        wr(OFS_PLL_PWR, 8'h80);
        wr(OFS_SRC_SEL, 8'h02);
        `CHK({srcInternalVco, pllPowerDown}, 2'b01)
        rd(OFS_VCO_DIV, {5'h00, rDiv[2:0]});
        rd(10'h3FF, 8'h00);
        upd;
        `CHK({srcInternalVco, vcoDivBypass, vcoDivRatio}, {2'b10, rDiv[2:0]})
        `CHK({pllPowerOn, pfdNegative, refInputEn}, {2'b11, rRef[2:0]})
        `CHK(pllPowerMode, PWR_NORMAL)
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SRC_SEL, 8'(i));
            upd;
            `CHK({srcInternalVco, vcoDivBypass}, 2'(i))
        end
        wr(OFS_NVM_CTRL, 8'h01);
        rd(OFS_NVM_CTRL, 8'h01);
        wr(OFS_SRC_SEL, 8'h00);
        upd;
        wr(OFS_NVM_CTRL, 8'h02);
        step(2);
        `CHK({srcInternalVco, vcoDivBypass}, 2'b11)
        rd(OFS_SRC_SEL, 8'h03);
        wr(OFS_VCO_CAL, 8'h01);
        upd;
        `CHK({calBusy, calDone}, 2'b10)
        step(CL);
        `CHK({calBusy, calDone}, 2'b01)
        upd;
        `CHK({calBusy, calDone}, 2'b01)
        wr(OFS_VCO_CAL, 8'h00);
        upd;
        `CHK({calBusy, calDone}, 2'b00)
        wr(OFS_VCO_CAL, 8'h01);
        upd;
        `CHK(calBusy, 1'b1)
        step(CL + 2);
        test_done;
    end
endmodule
`default_nettype wire
